// >>> design/dacdb_map.vh
// Constants for the double-buffered twelve-channel DAC load block
//
// What this block does
// - Twelve independent channels, each driven by its own 12-bit output code.
// - Each channel has an input word register ahead of an output latch; latch drives output.
// - Reading a channel's data location returns its output latch, not the pending word.
// - Sync-load select 0: latch takes the new word right after each write.
// - Sync-load select 1: writes change only the input word; latch waits for load.
// - Software writes 1 to config-0 load bit; device then makes the internal load.
// - A new latch code reaches the channel output with no further delay.
// - Reset sets every input word, latch and output code to zero.
// - After reset every output buffer is powered down, high impedance, pulled to ground.
// - Per-channel gain picks an output span of twice or five times reference.
// - One load trigger updates all pending sync-selected channels in the same cycle.
// - A trigger reloads only latches whose input word was written since last trigger.
`ifndef DACDB_MAP_VH
`define DACDB_MAP_VH

// ==========================================================
// Sizes
`define DACDB_NUM_CH 12
`define DACDB_CODE_W 12
`define DACDB_IDX_W 4

// ==========================================================
// Reset values
`define DACDB_CODE_RST 12'h000
`define DACDB_SEL_RST 12'h000
`define DACDB_GAIN_RST 12'h000
`define DACDB_PWR_RST 12'h000

// ==========================================================
// Field positions and encodings
`define DACDB_CFG0_LOAD_BIT 0
`define DACDB_GAIN_2X 1'b0
`define DACDB_GAIN_5X 1'b1

// ==========================================================
// Readback selector codes
`define DACDB_RD_LATCH 2'h0
`define DACDB_RD_SEL 2'h1
`define DACDB_RD_GAIN 2'h2
`define DACDB_RD_PWR 2'h3

`endif

// >>> design/dacdb_chan.v
// One channel: input word register, output latch and pending flag
`timescale 1ns/1ps
`include "dacdb_map.vh"

module dacdb_chan (
    input wire i_clk_sys,
    input wire i_nrst,
    input wire i_wr,
    input wire [`DACDB_CODE_W-1:0] i_data,
    input wire i_sync_sel,
    input wire i_load,
    output wire [`DACDB_CODE_W-1:0] o_latch,
    output wire o_pending,
    output wire o_updated
);

    reg [`DACDB_CODE_W-1:0] word_q;
    reg [`DACDB_CODE_W-1:0] latch_q;
    reg pending_q;
    reg updated_q;

    // ==========================================================
    // Input word and latch
    // A write and a trigger in the same cycle: the trigger moves the old word,
    // the new word stays pending for the next trigger, so no write is lost.
    always @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            word_q <= `DACDB_CODE_RST;
            latch_q <= `DACDB_CODE_RST;
            pending_q <= 1'b0;
            updated_q <= 1'b0;
        end else begin
            updated_q <= 1'b0;
            if (i_load && i_sync_sel && pending_q) begin
                latch_q <= word_q;
                pending_q <= 1'b0;
                updated_q <= 1'b1;
            end
            if (i_wr) begin
                word_q <= i_data;
                if (!i_sync_sel) begin
                    latch_q <= i_data;
                    pending_q <= 1'b0;
                    updated_q <= 1'b1;
                end else begin
                    pending_q <= 1'b1;
                end
            end
        end
    end

    // Latch drives the output directly, no extra stage
    assign o_latch = latch_q;
    assign o_pending = pending_q;
    assign o_updated = updated_q;

endmodule

// >>> design/dacdb_top.v
// Top of the twelve-channel double-buffered DAC load block
`timescale 1ns/1ps
`include "dacdb_map.vh"

module dacdb_top (
    input wire i_clk_sys,
    input wire i_nrst,
    input wire i_wr_en,
    input wire [`DACDB_IDX_W-1:0] i_wr_chan,
    input wire [`DACDB_CODE_W-1:0] i_wr_data,
    input wire i_sel_wr,
    input wire [`DACDB_NUM_CH-1:0] i_channel_sync_load_sel,
    input wire i_gain_wr,
    input wire [`DACDB_NUM_CH-1:0] i_gain,
    input wire i_pwr_wr,
    input wire [`DACDB_NUM_CH-1:0] i_pwr_up,
    input wire i_cfg0_wr,
    input wire [`DACDB_CODE_W-1:0] i_cfg0_data,
    input wire i_rd_en,
    input wire [1:0] i_rd_what,
    input wire [`DACDB_IDX_W-1:0] i_rd_chan,
    output wire [`DACDB_NUM_CH*`DACDB_CODE_W-1:0] o_dac_code,
    output wire [`DACDB_NUM_CH-1:0] o_gain_5x,
    output wire [`DACDB_NUM_CH-1:0] o_out_en,
    output wire [`DACDB_NUM_CH-1:0] o_pull_gnd,
    output wire [`DACDB_NUM_CH-1:0] o_pending,
    output wire [`DACDB_NUM_CH-1:0] o_updated,
    output wire o_load_pulse,
    output wire o_cfg0_load_rd,
    output wire [`DACDB_CODE_W-1:0] o_rd_data,
    output wire o_rd_valid,
    output wire o_wr_err
);

    // ==========================================================
    // Declarations
    reg [`DACDB_NUM_CH-1:0] sel_q;
    reg [`DACDB_NUM_CH-1:0] gain_q;
    reg [`DACDB_NUM_CH-1:0] pwr_q;
    reg internal_load_trigger_q;
    reg [`DACDB_CODE_W-1:0] rd_data_q;
    reg [`DACDB_CODE_W-1:0] rd_data_d;
    reg rd_valid_q;
    reg wr_err_q;
    wire [`DACDB_NUM_CH-1:0] chan_wr;
    wire [`DACDB_NUM_CH*`DACDB_CODE_W-1:0] latch_all;
    wire wr_chan_ok;
    wire rd_chan_ok;
    wire load_req;

    // ==========================================================
    // Helper functions
    // Index range check, used by the write and the read path
    function chan_valid;
        input [`DACDB_IDX_W-1:0] idx;
        begin
            chan_valid = (idx < `DACDB_NUM_CH);
        end
    endfunction

    // One-hot decode of a channel index; out-of-range gives all zero
    function [`DACDB_NUM_CH-1:0] chan_onehot;
        input [`DACDB_IDX_W-1:0] idx;
        integer k;
        begin
            chan_onehot = {`DACDB_NUM_CH{1'b0}};
            for (k = 0; k < `DACDB_NUM_CH; k = k + 1) begin
                if (idx == k[`DACDB_IDX_W-1:0]) begin
                    chan_onehot[k] = 1'b1;
                end
            end
        end
    endfunction

    // Pick one 12-bit code out of the packed latch vector
    function [`DACDB_CODE_W-1:0] code_of;
        input [`DACDB_NUM_CH*`DACDB_CODE_W-1:0] vec;
        input [`DACDB_IDX_W-1:0] idx;
        integer k;
        begin
            code_of = `DACDB_CODE_RST;
            for (k = 0; k < `DACDB_NUM_CH; k = k + 1) begin
                if (idx == k[`DACDB_IDX_W-1:0]) begin
                    code_of = vec[k*`DACDB_CODE_W +: `DACDB_CODE_W];
                end
            end
        end
    endfunction

    // Pick one bit of a per-channel vector, zero-extended to code width
    function [`DACDB_CODE_W-1:0] bit_of;
        input [`DACDB_NUM_CH-1:0] vec;
        input [`DACDB_IDX_W-1:0] idx;
        integer k;
        begin
            bit_of = `DACDB_CODE_RST;
            for (k = 0; k < `DACDB_NUM_CH; k = k + 1) begin
                if (idx == k[`DACDB_IDX_W-1:0]) begin
                    bit_of = {{(`DACDB_CODE_W-1){1'b0}}, vec[k]};
                end
            end
        end
    endfunction

    // ==========================================================
    // Write decode
    // Writes to a channel index beyond the bank are dropped and flagged
    assign wr_chan_ok = chan_valid(i_wr_chan);
    assign rd_chan_ok = chan_valid(i_rd_chan);
    assign chan_wr = i_wr_en ? chan_onehot(i_wr_chan) : {`DACDB_NUM_CH{1'b0}};

    // ==========================================================
    // Per-channel configuration
    // Select, gain and power bits update as whole vectors on their strobes
    always @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            sel_q <= `DACDB_SEL_RST;
            gain_q <= `DACDB_GAIN_RST;
            pwr_q <= `DACDB_PWR_RST;
        end else begin
            if (i_sel_wr) begin
                sel_q <= i_channel_sync_load_sel;
            end
            if (i_gain_wr) begin
                gain_q <= i_gain;
            end
            if (i_pwr_wr) begin
                pwr_q <= i_pwr_up;
            end
        end
    end

    // ==========================================================
    // Load trigger
    // Only a write of 1 to the load bit fires; the bit is not stored, so a
    // held strobe still gives one pulse per write cycle and reads back zero
    assign load_req = i_cfg0_wr && i_cfg0_data[`DACDB_CFG0_LOAD_BIT];
    always @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            internal_load_trigger_q <= 1'b0;
        end else begin
            internal_load_trigger_q <= load_req;
        end
    end
    assign o_load_pulse = internal_load_trigger_q;
    assign o_cfg0_load_rd = 1'b0;

    // ==========================================================
    // Channel bank
    // Every channel sees the same trigger cycle, so all selected ones with a pending word move together
    genvar g;
    generate
        for (g = 0; g < `DACDB_NUM_CH; g = g + 1) begin : g_chan
            dacdb_chan u_chan (
                .i_clk_sys(i_clk_sys),
                .i_nrst(i_nrst),
                .i_wr(chan_wr[g]),
                .i_data(i_wr_data),
                .i_sync_sel(sel_q[g]),
                .i_load(internal_load_trigger_q),
                .o_latch(latch_all[g*`DACDB_CODE_W +: `DACDB_CODE_W]),
                .o_pending(o_pending[g]),
                .o_updated(o_updated[g])
            );
        end
    endgenerate

    // ==========================================================
    // Analog-side outputs
    // Codes come straight from the latch flops so the output follows at once
    assign o_dac_code = latch_all;
    assign o_gain_5x = gain_q;
    // Buffer off means high impedance with the ground pull engaged
    assign o_out_en = pwr_q;
    assign o_pull_gnd = ~pwr_q;

    // ==========================================================
    // Readback mux
    // Data location returns the latch; the pending word is never visible here
    always @* begin
        rd_data_d = `DACDB_CODE_RST;
        if (!rd_chan_ok) begin
            rd_data_d = `DACDB_CODE_RST;
        end else if (i_rd_what == `DACDB_RD_LATCH) begin
            rd_data_d = code_of(latch_all, i_rd_chan);
        end else if (i_rd_what == `DACDB_RD_SEL) begin
            rd_data_d = bit_of(sel_q, i_rd_chan);
        end else if (i_rd_what == `DACDB_RD_GAIN) begin
            rd_data_d = bit_of(gain_q, i_rd_chan);
        end else begin
            rd_data_d = bit_of(pwr_q, i_rd_chan);
        end
    end

    // Read answer one cycle after the request, held until the next read
    always @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            rd_data_q <= `DACDB_CODE_RST;
            rd_valid_q <= 1'b0;
            wr_err_q <= 1'b0;
        end else begin
            rd_valid_q <= i_rd_en;
            if (i_rd_en) begin
                rd_data_q <= rd_data_d;
            end
            wr_err_q <= i_wr_en && !wr_chan_ok;
        end
    end
    assign o_rd_data = rd_data_q;
    assign o_rd_valid = rd_valid_q;
    assign o_wr_err = wr_err_q;

endmodule

// >>> verif/dacdb_monitor.sv
// Port-level checker for the double-buffered DAC load block
`timescale 1ns/1ps
`include "dacdb_map.vh"

module dacdb_monitor (
    input logic i_clk_sys,
    input logic i_nrst,
    input logic i_wr_en,
    input logic [3:0] i_wr_chan,
    input logic i_cfg0_wr,
    input logic [11:0] i_cfg0_data,
    input logic i_rd_en,
    input logic [1:0] i_rd_what,
    input logic [3:0] i_rd_chan,
    input logic i_gain_wr,
    input logic [11:0] i_gain,
    input logic [143:0] o_dac_code,
    input logic [11:0] o_gain_5x,
    input logic [11:0] o_out_en,
    input logic [11:0] o_pull_gnd,
    input logic [11:0] o_pending,
    input logic o_load_pulse,
    input logic o_cfg0_load_rd,
    input logic [11:0] o_rd_data,
    input logic o_rd_valid,
    input logic o_wr_err
);
    // ==========================================
    // One clock domain, so one default for all
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    sequence s_trig; i_cfg0_wr && i_cfg0_data[0]; endsequence
    sequence s_fire; o_load_pulse; endsequence
    property p_load; s_trig |=> s_fire; endproperty
    a_load: assert property (p_load) else $error("load pulse missing");
    property p_noload; !(i_cfg0_wr && i_cfg0_data[0]) |=> !o_load_pulse; endproperty
    a_noload: assert property (p_noload) else $error("stray load pulse");
    // Latch moves only on a write or a load, never on its own
    property p_hold; !o_load_pulse && !i_wr_en |=> $stable(o_dac_code); endproperty
    a_hold: assert property (p_hold) else $error("code moved unasked");
    property p_pend; !o_load_pulse && !i_wr_en |=> $stable(o_pending); endproperty
    a_pend: assert property (p_pend) else $error("pending moved unasked");
    // Read data is the latch as it stood at the request edge
    property p_rd;
        i_rd_en && i_rd_what == 2'h0 && i_rd_chan < 4'hC |=>
            o_rd_valid && o_rd_data == $past(o_dac_code[i_rd_chan*12 +: 12]);
    endproperty
    a_rd: assert property (p_rd) else $error("readback not latch");
    property p_err; i_wr_en && i_wr_chan > 4'hB |=> o_wr_err; endproperty
    a_err: assert property (p_err) else $error("bad index not flagged");
    property p_gain; i_gain_wr |=> o_gain_5x == $past(i_gain); endproperty
    a_gain: assert property (p_gain) else $error("gain not taken");
    property p_pull; o_pull_gnd == ~o_out_en; endproperty
    a_pull: assert property (p_pull) else $error("pull and enable clash");
    property p_cfgrd; o_cfg0_load_rd == 1'h0; endproperty
    a_cfgrd: assert property (p_cfgrd) else $error("load bit reads one");
endmodule

// >>> verif/test_dac_double_buffer_load.sv
// Self-checking bench for the double-buffered DAC load block
`timescale 1ns/1ps
`include "dacdb_map.vh"
`define CHK(n,e,a) begin check_count++; if ((a) !== (e)) begin err_count++; \
    $display("unexpected %s exp %0h got %0h", n, e, a); end end

module test_dac_double_buffer_load;
    logic clk = 0, nrst = 0, wr_en = 0, sel_wr = 0, gain_wr = 0, pwr_wr = 0, cfg_wr = 0;
    logic rd_en = 0;
    logic [3:0] wr_ch = 0, rd_ch = 0;
    logic [1:0] rd_what = 0;
    logic [11:0] wr_d = 0, sel = 0, gain = 0, pwr = 0, cfg_d = 0;
    wire [143:0] code;
    wire [11:0] g5, oe, pg, pend, upd, rdd;
    wire lp, cfg_rd, rdv, werr;
    logic [143:0] snap;
    int err_count = 0, check_count = 0, cycles = 0;

    always #5 clk = ~clk;

    dacdb_top dacdb_top_inst (.i_clk_sys(clk), .i_nrst(nrst), .i_wr_en(wr_en),
        .i_wr_chan(wr_ch), .i_wr_data(wr_d), .i_sel_wr(sel_wr), .i_channel_sync_load_sel(sel),
        .i_gain_wr(gain_wr), .i_gain(gain), .i_pwr_wr(pwr_wr), .i_pwr_up(pwr),
        .i_cfg0_wr(cfg_wr), .i_cfg0_data(cfg_d), .i_rd_en(rd_en), .i_rd_what(rd_what),
        .i_rd_chan(rd_ch), .o_dac_code(code), .o_gain_5x(g5), .o_out_en(oe), .o_pull_gnd(pg),
        .o_pending(pend), .o_updated(upd), .o_load_pulse(lp), .o_cfg0_load_rd(cfg_rd),
        .o_rd_data(rdd), .o_rd_valid(rdv), .o_wr_err(werr));

    // ==========================================
    // Bus helpers: each op idles a cycle first so no strobe is set twice in one step
    task automatic tick; @(negedge clk); endtask
    function automatic logic [11:0] cc(input int n); return code[n*12 +: 12]; endfunction
    task automatic wr(input logic [3:0] c, input logic [11:0] d);
        tick; wr_en = 1; wr_ch = c; wr_d = d; tick; wr_en = 0;
    endtask
    task automatic rd(input logic [3:0] c, input logic [1:0] w);
        tick; rd_en = 1; rd_ch = c; rd_what = w; tick; rd_en = 0;
        `CHK("rd_valid", 1'h1, rdv)
    endtask
    task automatic vec(input int k, input logic [11:0] v);
        tick; sel = v; gain = v; pwr = v;
        sel_wr = (k == 0); gain_wr = (k == 1); pwr_wr = (k == 2);
        tick; sel_wr = 0; gain_wr = 0; pwr_wr = 0;
    endtask
    // Load request; returns once the latches had their edge
    task automatic cfg(input logic [11:0] v);
        tick; cfg_wr = 1; cfg_d = v; tick; cfg_wr = 0;
        `CHK("load_pulse", v[0], lp)
        tick;
    endtask

    // ==========================================
    // Scenarios
    task automatic t_reset;
        `CHK("code", 144'h0, code)
        `CHK("pending", 12'h000, pend)
        `CHK("out_en", 12'h000, oe)
        `CHK("pull_gnd", 12'hFFF, pg)
        `CHK("cfg0_rd", 1'h0, cfg_rd)
    endtask
    task automatic t_async;
        vec(0, 12'h000);
        wr(2, 12'hABC);
        `CHK("ch2", 12'hABC, cc(2))
        `CHK("updated", 12'h004, upd)
        wr(11, 12'h5A5);
        `CHK("ch11", 12'h5A5, cc(11))
        rd(2, 0);
        `CHK("rd_data", 12'hABC, rdd)
    endtask
    task automatic t_sync;
        vec(0, 12'h801);
        wr(0, 12'h123);
        wr(11, 12'hFFF);
        `CHK("ch0", 12'h000, cc(0))
        `CHK("ch11", 12'h5A5, cc(11))
        `CHK("pending", 12'h801, pend)
        rd(11, 0);
        `CHK("rd_data", 12'h5A5, rdd)
        cfg(12'h000);
        `CHK("pending", 12'h801, pend)
        cfg(12'h001);
        `CHK("ch0", 12'h123, cc(0))
        `CHK("ch11", 12'hFFF, cc(11))
        `CHK("updated", 12'h801, upd)
        `CHK("pending", 12'h000, pend)
        wr(11, 12'h0EE);
        cfg(12'h001);
        `CHK("updated", 12'h800, upd)
        `CHK("ch11", 12'h0EE, cc(11))
    endtask
    task automatic t_misc;
        snap = code;
        wr(12, 12'h777);
        `CHK("wr_err", 1'h1, werr)
        `CHK("code", snap, code)
        vec(1, 12'hA5A);
        `CHK("gain_5x", 12'hA5A, g5)
        rd(1, 2);
        `CHK("rd_gain", 12'h001, rdd)
        vec(2, 12'h0F0);
        `CHK("out_en", 12'h0F0, oe)
        `CHK("pull_gnd", 12'hF0F, pg)
        rd(4, 3);
        `CHK("rd_pwr", 12'h001, rdd)
    endtask
    // Write landing in the load cycle, the select and refused reads, then a second reset
    task automatic t_edge;
        wr(11, 12'h111);
        tick;
        cfg_wr = 1;
        cfg_d = 12'h001;
        tick;
        cfg_wr = 0;
        wr_en = 1;
        wr_ch = 11;
        wr_d = 12'h222;
        tick;
        wr_en = 0;
        tick;
        `CHK("ch11_old", 12'h111, cc(11))
        `CHK("pending", 12'h800, pend)
        cfg(12'h001);
        `CHK("ch11_new", 12'h222, cc(11))
        rd(0, 1);
        `CHK("rd_sel", 12'h001, rdd)
        rd(12, 0);
        `CHK("rd_refused", 12'h000, rdd)
        tick;
        nrst = 0;
        repeat (2) tick;
        `CHK("code", 144'h0, code)
        `CHK("pending", 12'h000, pend)
        `CHK("updated", 12'h000, upd)
        `CHK("gain_5x", 12'h000, g5)
        `CHK("out_en", 12'h000, oe)
        `CHK("pull_gnd", 12'hFFF, pg)
        `CHK("load_pulse", 1'h0, lp)
        nrst = 1;
        tick;
        `CHK("code", 144'h0, code)
        wr(2, 12'h3C3);
        `CHK("ch2", 12'h3C3, cc(2))
    endtask

    task automatic final_report;
        $display("errors %0d checks %0d", err_count, check_count);
        if (err_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Hang guard: the whole run needs well under a hundred cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            final_report;
        end
    end

    initial begin
        repeat (8) @(negedge clk);
        nrst = 1;
        tick;
        t_reset;
        t_async;
        t_sync;
        t_misc;
        t_edge;
        final_report;
    end
endmodule

bind dacdb_top dacdb_monitor dacdb_monitor_inst (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
    .i_wr_en(i_wr_en), .i_wr_chan(i_wr_chan), .i_cfg0_wr(i_cfg0_wr), .i_cfg0_data(i_cfg0_data),
    .i_rd_en(i_rd_en), .i_rd_what(i_rd_what), .i_rd_chan(i_rd_chan), .i_gain_wr(i_gain_wr),
    .i_gain(i_gain), .o_dac_code(o_dac_code), .o_gain_5x(o_gain_5x), .o_out_en(o_out_en),
    .o_pull_gnd(o_pull_gnd), .o_pending(o_pending), .o_load_pulse(o_load_pulse),
    .o_cfg0_load_rd(o_cfg0_load_rd), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
    .o_wr_err(o_wr_err));
